// file: sim/split_sensor_readout_trigger_bench.sv
// self-checking bench for the split-view readout timing controller
`timescale 1ns/1ps
`default_nettype none
`include "split_readout_defines.svh"
module split_sensor_readout_trigger_bench;
    logic clk = 0, rst_n = 0, fire = 0, trig, awvalid = 0, wvalid = 0;
    logic bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid;
    logic arready, rvalid, gexp_out, prog_out, expose_top_out, expose_bot_out;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, got, r1;
    logic [1:0] bresp, rresp, resp;
    int errors = 0, comparisons = 0, seed = 85;
    int cyc = 0, t_trg = 0, dly = 0, wid = 0, gc = 0, t_top = 0, per = 0, g0;
    split_sensor_readout_trigger u_dut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig_in(trig),
        .gexp_out(gexp_out), .prog_out(prog_out),
        .expose_top_out(expose_top_out), .expose_bot_out(expose_bot_out));
    trig_source u_src (.clk(clk), .fire(fire), .trig(trig));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        gc <= gc + gexp_out;
        wid <= wid + prog_out;
        if ($rose(trig)) t_trg <= cyc;
        if ($rose(prog_out)) dly <= cyc - t_trg;
        if ($rose(expose_top_out)) t_top <= cyc;
        if ($rose(expose_top_out)) per <= cyc - t_top;
    end
    function automatic int frame_cyc(input int e, input int lp, input int vn);
        return ((e * `US_CYCLES + lp - 1) / lp + vn + `GAP_LINES) * lp;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) errors++;
        if (s !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    endtask
    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic hs(input logic w);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (arready) arvalid <= 1'h0;
            if (w ? bvalid : rvalid) break;
        end
        bready <= 1'h0;
        rready <= 1'h0;
        got = rdata;
        resp = w ? bresp : rresp;
        if (i == 40) chk("bus timeout", 0, 1);
        if (i == 40) finish_test;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        hs(1'h1);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m, e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        hs(1'h0);
        chk(n, got & m, e);
    endtask
    // free-run split frames are under 6000 clocks with these settings
    task automatic gx(input logic [31:0] c, input int e);
        wr(`OFS_CTRL, c);
        repeat (6000) @(posedge clk);
        g0 = gc;
        repeat (6000) @(posedge clk);
        chk("gexp seen", gc > g0, e);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        rc("exp rst", `OFS_EXP_TOP, '1, `EXP_RESET);
        rc("line rst", `OFS_LINE_PERIOD, '1, 32'h186);
        rc("unmapped", 8'h40, '1, 32'h0);
        chk("rresp", resp, 2'h2);
        r1 = $random(seed);
        wr(`OFS_SUB_POS_TOP, r1);
        wr(`OFS_SUB_POS_BOT, ~r1);
        rc("pos top", `OFS_SUB_POS_TOP, '1, r1 & 32'h0FFC0FFC);
        rc("pos bot", `OFS_SUB_POS_BOT, '1, ~r1 & 32'h0FFC0FFC);
        $display("test registers done");
        wr(`OFS_SUB_SIZE, 32'h40800);
        wr(`OFS_EXP_TOP, 32'h14);
        wr(`OFS_EXP_BOT, 32'h14);
        wr(`OFS_PROG_DELAY, 32'h2);
        wr(`OFS_PROG_WIDTH, 32'h3);
        wr(`OFS_CTRL, 32'h109);
        g0 = wid;
        fire <= 1'h1;
        @(posedge clk);
        fire <= 1'h0;
        repeat (400) @(posedge clk);
        chk("prog width", wid - g0, 3 * `US_CYCLES);
        chk("prog delay", dly > 78 && dly < 90, 1);
        $display("test trigger done");
        wr(`OFS_EXP_TOP, 32'h64);
        gx(32'h43, 1);
        rc("shutter", `OFS_STATUS, 32'hC, 32'h8);
        gx(32'h3, 0);
        wr(`OFS_EXP_TOP, 32'h14);
        gx(32'h43, 0);
        rc("both shut", `OFS_STATUS, 32'hC, 32'hC);
        $display("test split done");
        wr(`OFS_CTRL, 32'h5);
        repeat (20000) @(posedge clk);
        chk("dual frame", per, frame_cyc(20, 390, 4));
        wr(`OFS_CTRL, 32'h805);
        rc("no binning", `OFS_CTRL, 32'h1800, 32'h0);
        rc("bin flag", `OFS_STATUS, 32'h20, 32'h20);
        wr(`OFS_CTRL, 32'h1D);
        rc("mode refused", `OFS_STATUS, 32'h10, 32'h10);
        $display("test dual done");
        finish_test;
    end
endmodule // split_sensor_readout_trigger_bench
`default_nettype wire

// file: sim/trig_source.sv
// external trigger source driving the camera trigger input
`timescale 1ns/1ps
`default_nettype none
module trig_source (
    input wire logic clk,
    input wire logic fire,
    output logic trig
);
    int n = 0;
    initial trig = 1'h0;
    // each trigger stays high four clocks so the edge is caught
    always @(posedge clk) begin
        if (fire) n <= 4;
        else if (n != 0) n <= n - 1;
        trig <= fire || n > 1;
    end
endmodule // trig_source
`default_nettype wire

// file: src/prog_pulse_timer.sv
// delayed pulse generator counting microsecond ticks from a restart event
`timescale 1ns/1ps
`default_nettype none
`include "split_readout_defines.svh"
module prog_pulse_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [31:0] delay_us,
    input wire logic [31:0] width_us,
    output logic pulse_r
);
    localparam logic [5:0] US_LAST = 6'(`US_CYCLES - 1);
    logic [5:0] pre_r;
    logic [31:0] cnt_r;
    logic delaying_r;
    wire tick = (pre_r == US_LAST);
    wire [31:0] cnt_inc = cnt_r + 32'h0000_0001;
    wire [31:0] width_eff = (width_us == 32'h0) ? 32'h0000_0001 : width_us;

    // prescaler restarts with the event so the delay is exact
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 6'h00;
            cnt_r <= 32'h0;
            delaying_r <= 1'b0;
            pulse_r <= 1'b0;
        end else if (start) begin
            pre_r <= 6'h00;
            cnt_r <= 32'h0;
            delaying_r <= (delay_us != 32'h0);
            pulse_r <= (delay_us == 32'h0);
        end else begin
            pre_r <= tick ? 6'h00 : pre_r + 6'h01;
            if (tick && delaying_r) begin
                cnt_r <= (cnt_inc == delay_us) ? 32'h0 : cnt_inc;
                delaying_r <= (cnt_inc != delay_us);
                pulse_r <= (cnt_inc == delay_us);
            end else if (tick && pulse_r) begin
                cnt_r <= cnt_inc;
                pulse_r <= (cnt_inc < width_eff);
            end
        end
    end
endmodule // prog_pulse_timer
`default_nettype wire

// file: src/readout_pkg.sv
// types shared by the readout timing controller
package readout_pkg;
    typedef enum logic [1:0] {
        ST_WAIT = 2'b00,
        ST_EXPOSE = 2'b01,
        ST_READ = 2'b11,
        ST_GAP = 2'b10
    } frame_state_e;

    typedef enum logic [2:0] {
        TM_FREE = 3'h0,
        TM_EDGE = 3'h1,
        TM_GR_EDGE = 3'h2,
        TM_LEVEL = 3'h3,
        TM_GR_LEVEL = 3'h4,
        TM_SYNC = 3'h5,
        TM_START = 3'h6
    } trig_mode_e;

    typedef enum logic [1:0] {
        REF_READ_END = 2'h0,
        REF_VSYNC = 2'h1,
        REF_TRIGGER = 2'h2
    } prog_ref_e;
endpackage

// file: src/split_readout_defines.svh
// register map, field positions, reset values and timing counts
// Notes on behaviour
// - free run: shutter only the shorter half
// - both shorter than readout: shutter both halves
// - edge, reset-edge, start: separate half exposures
// - level, reset-level, sync: one common exposure
// - global exposure pulse while half fully exposing
// - setting picks longer or shorter half pulse
// - no global pulse if both halves short
// - read end reference: delay from readout end
// - vsync reference: delay from readout start
// - trigger reference: delay from input trigger
// - dual sheet: separate window position per half
// - dual sheet: per half direction, four combos
// - dual sheet forbids binning
// - window size and position step granularity
// - dual sheet: only free, edge, start
// - dual frame: exposure plus active+10 lines
// - dual exposure: one line up to 10 s
// - exposure rounds up to whole lines
// - split halves end exposure together
`ifndef SPLIT_READOUT_DEFINES_SVH
`define SPLIT_READOUT_DEFINES_SVH

`define OFS_CTRL 8'h00
`define OFS_EXP_TOP 8'h04
`define OFS_EXP_BOT 8'h08
`define OFS_LINE_PERIOD 8'h0C
`define OFS_SUB_SIZE 8'h10
`define OFS_SUB_POS_TOP 8'h14
`define OFS_SUB_POS_BOT 8'h18
`define OFS_PROG_DELAY 8'h1C
`define OFS_PROG_WIDTH 8'h20
`define OFS_STATUS 8'h24

`define CTRL_RUN 0
`define CTRL_SPLIT 1
`define CTRL_DUAL 2
`define CTRL_MODE_LO 3
`define CTRL_MODE_HI 5
`define CTRL_GEXP_LONG 6
`define CTRL_REF_LO 7
`define CTRL_REF_HI 8
`define CTRL_DIR_TOP 9
`define CTRL_DIR_BOT 10
`define CTRL_BIN_LO 11
`define CTRL_BIN_HI 12
`define STAT_BIN_REFUSED 5

`define CTRL_RESET 32'h0000_0000
`define EXP_RESET 32'h0000_2710
`define HSIZE_RESET 12'h800
`define VSIZE_RESET 12'h400
`define HSIZE_MASK 12'hF80
`define STEP4_MASK 12'hFFC

`define CLK_PERIOD_PS 25000
`define US_PS 1000000
`define US_CYCLES (`US_PS / `CLK_PERIOD_PS)
`define LINE_MIN_PS 9744360
`define LINE_MIN_CYCLES ((`LINE_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define EXP_MAX_US 10000000
`define PROG_MAX_US 10000000
`define GAP_LINES 10

`endif

// file: src/split_sensor_readout_trigger.sv
// split-view sensor timing controller with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "split_readout_defines.svh"
module split_sensor_readout_trigger import readout_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trig_in,
    output logic gexp_out,
    output logic prog_out,
    output logic expose_top_out,
    output logic expose_bot_out
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl_r, exp_top_r, exp_bot_r, line_period_r;
    logic [11:0] hsize_r, vsize_r, hpos_top_r, vpos_top_r;
    logic [11:0] hpos_bot_r, vpos_bot_r;
    logic [31:0] prog_delay_r, prog_width_r;
    logic bin_refused_r, shut_top_r, shut_bot_r;

    ////////////////////////////////////////////////////////////////////////
    // bus slave
    logic aw_full_r, w_full_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    wire do_write = aw_full_r && w_full_r && !s_axi_bvalid;
    wire we_ctrl = do_write && (waddr_r == `OFS_CTRL);
    wire we_exp_top = do_write && (waddr_r == `OFS_EXP_TOP);
    wire we_exp_bot = do_write && (waddr_r == `OFS_EXP_BOT);
    wire we_line = do_write && (waddr_r == `OFS_LINE_PERIOD);
    wire we_size = do_write && (waddr_r == `OFS_SUB_SIZE);
    wire we_pos_top = do_write && (waddr_r == `OFS_SUB_POS_TOP);
    wire we_pos_bot = do_write && (waddr_r == `OFS_SUB_POS_BOT);
    wire we_delay = do_write && (waddr_r == `OFS_PROG_DELAY);
    wire we_width = do_write && (waddr_r == `OFS_PROG_WIDTH);
    wire we_status = do_write && (waddr_r == `OFS_STATUS);
    wire w_mapped = we_ctrl | we_exp_top | we_exp_bot | we_line | we_size
        | we_pos_top | we_pos_bot | we_delay | we_width | we_status;

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    wire [31:0] size_word = {4'h0, vsize_r, 4'h0, hsize_r};
    wire [31:0] pos_top_word = {4'h0, vpos_top_r, 4'h0, hpos_top_r};
    wire [31:0] pos_bot_word = {4'h0, vpos_bot_r, 4'h0, hpos_bot_r};
    wire [31:0] ctrl_nw = merge(ctrl_r, wdata_r, wstrb_r);
    wire [31:0] size_nw = merge(size_word, wdata_r, wstrb_r);
    wire [31:0] pos_top_nw = merge(pos_top_word, wdata_r, wstrb_r);
    wire [31:0] pos_bot_nw = merge(pos_bot_word, wdata_r, wstrb_r);
    wire [31:0] line_nw = merge(line_period_r, wdata_r, wstrb_r);
    wire [31:0] exp_top_nw = merge(exp_top_r, wdata_r, wstrb_r);
    wire [31:0] exp_bot_nw = merge(exp_bot_r, wdata_r, wstrb_r);
    wire bin_req = (ctrl_nw[`CTRL_BIN_HI:`CTRL_BIN_LO] != 2'b00);
    wire bin_reject = bin_req && ctrl_nw[`CTRL_DUAL];
    // binning field is dropped whenever dual light-sheet is on
    wire [31:0] ctrl_nxt = bin_reject ? {ctrl_nw[31:13], 2'b00, ctrl_nw[10:0]}
        : ctrl_nw;
    localparam logic [31:0] LINE_MIN = 32'(`LINE_MIN_CYCLES);
    localparam logic [31:0] EXP_MAX = 32'(`EXP_MAX_US);
    localparam logic [31:0] PROG_MAX = 32'(`PROG_MAX_US);
    wire [31:0] line_nxt = (line_nw < LINE_MIN) ? LINE_MIN : line_nw;
    wire [31:0] exp_top_nxt = (exp_top_nw > EXP_MAX) ? EXP_MAX : exp_top_nw;
    wire [31:0] exp_bot_nxt = (exp_bot_nw > EXP_MAX) ? EXP_MAX : exp_bot_nw;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                waddr_r <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_mapped ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `CTRL_RESET;
            exp_top_r <= `EXP_RESET;
            exp_bot_r <= `EXP_RESET;
            line_period_r <= 32'(`LINE_MIN_CYCLES);
            hsize_r <= `HSIZE_RESET;
            vsize_r <= `VSIZE_RESET;
            hpos_top_r <= 12'h000;
            vpos_top_r <= 12'h000;
            hpos_bot_r <= 12'h000;
            vpos_bot_r <= 12'h000;
            prog_delay_r <= 32'h0;
            prog_width_r <= 32'h0000_0001;
        end else begin
            if (we_ctrl) ctrl_r <= ctrl_nxt;
            if (we_exp_top) exp_top_r <= exp_top_nxt;
            if (we_exp_bot) exp_bot_r <= exp_bot_nxt;
            if (we_line) line_period_r <= line_nxt;
            if (we_size) begin
                hsize_r <= size_nw[11:0] & `HSIZE_MASK;
                vsize_r <= size_nw[27:16] & `STEP4_MASK;
            end
            if (we_pos_top) begin
                hpos_top_r <= pos_top_nw[11:0] & `STEP4_MASK;
                vpos_top_r <= pos_top_nw[27:16] & `STEP4_MASK;
            end
            if (we_pos_bot) begin
                hpos_bot_r <= pos_bot_nw[11:0] & `STEP4_MASK;
                vpos_bot_r <= pos_bot_nw[27:16] & `STEP4_MASK;
            end
            if (we_delay) prog_delay_r <= (wdata_r > PROG_MAX) ? PROG_MAX
                : wdata_r;
            if (we_width) prog_width_r <= (wdata_r > PROG_MAX) ? PROG_MAX
                : ((wdata_r == 32'h0) ? 32'h0000_0001 : wdata_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    wire run = ctrl_r[`CTRL_RUN];
    wire split = ctrl_r[`CTRL_SPLIT];
    wire dual = ctrl_r[`CTRL_DUAL];
    wire gexp_long = ctrl_r[`CTRL_GEXP_LONG];
    wire dir_top = ctrl_r[`CTRL_DIR_TOP];
    wire dir_bot = ctrl_r[`CTRL_DIR_BOT];
    trig_mode_e mode;
    prog_ref_e pref;
    assign mode = trig_mode_e'(ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO]);
    assign pref = prog_ref_e'(ctrl_r[`CTRL_REF_HI:`CTRL_REF_LO]);
    wire level_mode = (mode == TM_LEVEL) || (mode == TM_GR_LEVEL);
    wire common_exp = level_mode || (mode == TM_SYNC);
    wire mode_refused = dual && !((mode == TM_FREE) || (mode == TM_EDGE)
        || (mode == TM_START));
    wire [31:0] top_us = exp_top_r;
    wire [31:0] bot_us = common_exp ? exp_top_r : exp_bot_r;
    wire top_longer = (top_us >= bot_us);
    wire [31:0] long_us = top_longer ? top_us : bot_us;
    wire [39:0] readout_cyc = 40'(vsize_r) * 40'(line_period_r[27:0]);
    wire [39:0] top_cyc = 40'(top_us) * 40'(`US_CYCLES);
    wire [39:0] bot_cyc = 40'(bot_us) * 40'(`US_CYCLES);
    wire top_short = (top_cyc < readout_cyc);
    wire bot_short = (bot_cyc < readout_cyc);
    wire both_short = top_short && bot_short;

    ////////////////////////////////////////////////////////////////////////
    // trigger input synchroniser
    logic trig_s1_r, trig_s2_r, trig_d_r, start_armed_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r <= 1'b0;
        end else begin
            trig_s1_r <= trig_in;
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
        end
    end
    wire trig_edge = trig_s2_r && !trig_d_r;

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer
    frame_state_e state_r, state_nxt;
    logic [31:0] line_cyc_r, elapsed_us_r;
    logic [11:0] line_idx_r;
    logic [5:0] us_pre_r;
    wire line_end = (line_cyc_r >= line_period_r - 32'h1);
    wire us_tick = (us_pre_r == 6'(`US_CYCLES - 1));
    wire free_go = (mode == TM_FREE) || ((mode == TM_START) && start_armed_r);
    wire frame_go = run && !mode_refused && (free_go || trig_edge);
    wire exp_done = level_mode ? !trig_s2_r
        : (elapsed_us_r >= long_us);
    wire read_done = line_end && (line_idx_r >= vsize_r - 12'h1);
    wire gap_done = line_end && (line_idx_r == 12'(`GAP_LINES - 1));

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_WAIT: if (frame_go) state_nxt = ST_EXPOSE;
            ST_EXPOSE: if (line_end && exp_done) state_nxt = ST_READ;
            ST_READ: if (read_done) state_nxt = dual ? ST_GAP
                : ST_WAIT;
            // back-to-back frames skip the idle cycle to keep the period
            ST_GAP: if (gap_done) state_nxt = frame_go ? ST_EXPOSE
                : ST_WAIT;
        endcase
        if (!run) state_nxt = ST_WAIT;
    end

    wire leave_state = (state_nxt != state_r);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_WAIT;
            line_cyc_r <= 32'h0;
            line_idx_r <= 12'h000;
            elapsed_us_r <= 32'h0;
            us_pre_r <= 6'h00;
            start_armed_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            line_cyc_r <= (leave_state || line_end) ? 32'h0
                : line_cyc_r + 32'h1;
            if (leave_state) line_idx_r <= 12'h000;
            else if (line_end) line_idx_r <= line_idx_r + 12'h001;
            if (state_r != ST_EXPOSE) begin
                us_pre_r <= 6'h00;
                elapsed_us_r <= 32'h0;
            end else begin
                us_pre_r <= us_tick ? 6'h00 : us_pre_r + 6'h01;
                if (us_tick) elapsed_us_r <= elapsed_us_r + 32'h1;
            end
            if (!run || mode != TM_START) start_armed_r <= 1'b0;
            else if (trig_edge) start_armed_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // half exposure windows, end-aligned
    wire [32:0] top_reach = 33'(elapsed_us_r) + 33'(top_us);
    wire [32:0] bot_reach = 33'(elapsed_us_r) + 33'(bot_us);
    wire in_exp = (state_r == ST_EXPOSE);
    // shorter half starts late so both stop together
    wire top_exp = in_exp && (level_mode || top_reach >= 33'(long_us));
    wire bot_exp = in_exp && (level_mode || bot_reach >= 33'(long_us));
    wire sel_top = (gexp_long == top_longer);
    wire sel_exp = sel_top ? top_exp : bot_exp;
    wire sel_short = sel_top ? top_short : bot_short;
    wire gexp_nxt = split && !dual && sel_exp && !sel_short
        && !both_short;
    wire free_split = split && (mode == TM_FREE);
    wire shut_top_nxt = free_split && (both_short
        || (top_us < bot_us));
    wire shut_bot_nxt = free_split && (both_short
        || (bot_us < top_us));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gexp_out <= 1'b0;
            expose_top_out <= 1'b0;
            expose_bot_out <= 1'b0;
            shut_top_r <= 1'b0;
            shut_bot_r <= 1'b0;
            bin_refused_r <= 1'b0;
        end else begin
            gexp_out <= gexp_nxt;
            expose_top_out <= top_exp;
            expose_bot_out <= bot_exp;
            shut_top_r <= shut_top_nxt;
            shut_bot_r <= shut_bot_nxt;
            // a new refusal wins over a clear in the same cycle
            if (we_ctrl && bin_reject) bin_refused_r <= 1'b1;
            else if (we_status && wdata_r[`STAT_BIN_REFUSED])
                bin_refused_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // programmable timing output
    wire ev_vsync = (state_r == ST_EXPOSE) && (state_nxt == ST_READ);
    wire ev_read_end = (state_r == ST_READ) && (state_nxt != ST_READ);
    wire prog_start = ((pref == REF_READ_END) && ev_read_end)
        || ((pref == REF_VSYNC) && ev_vsync)
        || ((pref == REF_TRIGGER) && trig_edge);
    prog_pulse_timer u_prog (
        .clk(clk),
        .rst_n(rst_n),
        .start(prog_start),
        .delay_us(prog_delay_r),
        .width_us(prog_width_r),
        .pulse_r(prog_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path
    wire [31:0] status_word = {26'h0, bin_refused_r, mode_refused,
        shut_bot_r, shut_top_r, state_r};
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire r_mapped = (ra <= `OFS_STATUS);
    wire [31:0] rd_mux = (ra == `OFS_CTRL) ? ctrl_r
        : (ra == `OFS_EXP_TOP) ? exp_top_r
        : (ra == `OFS_EXP_BOT) ? exp_bot_r
        : (ra == `OFS_LINE_PERIOD) ? line_period_r
        : (ra == `OFS_SUB_SIZE) ? size_word
        : (ra == `OFS_SUB_POS_TOP) ? pos_top_word
        : (ra == `OFS_SUB_POS_BOT) ? pos_bot_word
        : (ra == `OFS_PROG_DELAY) ? prog_delay_r
        : (ra == `OFS_PROG_WIDTH) ? prog_width_r
        : (ra == `OFS_STATUS) ? status_word : 32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= r_mapped ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    shutter_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
        (free_split && top_us < bot_us && !both_short) |=> shut_top_r
            && !shut_bot_r) else $error("wrong shutter half");
    shutter_both_a: assert property (@(posedge clk) disable iff (!rst_n)
        (free_split && both_short) |=> (shut_top_r && shut_bot_r))
        else $error("both halves not shuttered");
    common_exp_a: assert property (@(posedge clk) disable iff (!rst_n)
        (common_exp && in_exp) |-> ##1 (expose_top_out == expose_bot_out))
        else $error("halves differ in common mode");
    gexp_short_a: assert property (@(posedge clk) disable iff (!rst_n)
        both_short |=> !gexp_out) else $error("global pulse while short");
    bin_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        dual |-> (ctrl_r[`CTRL_BIN_HI:`CTRL_BIN_LO] == 2'b00))
        else $error("binning with dual sheet");
    sub_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (hsize_r[6:0] == 7'h00) && (vsize_r[1:0] == 2'b00)
        && (vpos_top_r[1:0] == 2'b00) && (hpos_bot_r[1:0] == 2'b00))
        else $error("window off step");
    mode_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_refused && state_r == ST_WAIT) [*2] |-> state_r == ST_WAIT)
        else $error("refused mode started frame");
    gap_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (dual && run && $fell(state_r == ST_READ)) |-> state_r == ST_GAP)
        else $error("dual frame lacks gap lines");
    exp_round_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ev_vsync && !level_mode) |-> (elapsed_us_r >= long_us) && line_end)
        else $error("exposure cut short");
    end_align_a: assert property (@(posedge clk) disable iff (!rst_n)
        ev_vsync |=> (expose_top_out && expose_bot_out))
        else $error("halves end apart");
endmodule // split_sensor_readout_trigger
`default_nettype wire
